// [rtl/mhc_command_unit.sv]
// text command interpreter: signal level, link drop, channel group, restore, mute
`timescale 1ns/1ns
module mhc_command_unit #(
   parameter int RX_WIDTH = 8,
   parameter int RX_DEPTH = 2
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic cmd_valid_i,
   input wire logic [7:0] cmd_data_i,
   output logic cmd_ready_o,
   output logic resp_valid_o,
   output logic [7:0] resp_data_o,
   input wire logic resp_ready_i,
   input wire logic rs485_mode_i,
   input wire logic [23:0] station_addr_i,
   input wire logic [23:0] group_addr_i,
   input wire logic transparent_mode_i,
   input wire logic link_up_i,
   output logic drop_req_o,
   input wire logic drop_done_i,
   input wire logic drop_fail_i,
   input wire logic rssi_valid_i,
   input wire logic signed [7:0] rssi_dbm_i,
   input wire logic [2:0] default_method_i,
   input wire logic [6:0] default_group_i,
   output logic [2:0] grp_method_o,
   output logic [6:0] grp_num_o,
   output logic factory_restore_o,
   output logic station_addr_reset_o,
   output logic rx_muted_o,
   input wire logic rx_valid_i,
   input wire logic [RX_WIDTH-1:0] rx_data_i,
   output logic rx_ready_o,
   output logic term_valid_o,
   output logic [RX_WIDTH-1:0] term_data_o,
   input wire logic term_ready_i
);
   import mhc_pkg::*;

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   mhc_pkg::mhc_state_type state;
   mhc_pkg::mhc_state_type next_state;
   logic [7:0] line_buf [0:LINE_DEPTH-1];
   logic [3:0] line_len;
   logic in_line;
   logic saw_cr;
   logic too_long;
   logic take;
   logic line_done;
   logic [7:0] resp_buf [0:RESP_DEPTH-1];
   logic [3:0] resp_len;
   logic [3:0] resp_idx;
   logic slot_free;
   logic drop_pend;
   logic defaults_loaded;
   logic signed [7:0] rssi_last;
   logic buf_valid;
   logic [RX_WIDTH-1:0] buf_data;
   logic buf_ready;
   // decode results
   logic [23:0] name;
   logic grp_set;
   logic [3:0] base;
   logic [3:0] rest;
   logic has_addr;
   logic [23:0] addr;
   logic bad;
   logic skip;
   logic [2:0] set_method;
   logic [7:0] set_num;
   logic set_ok;
   logic load_resp;
   logic [7:0] next_resp [0:RESP_BODY-1];
   logic [3:0] next_resp_n;
   logic signed [7:0] rssi_clamp;
   logic [6:0] mag;
   logic [6:0] mag_rem;

   // ------------------------------------------------------------
   // line collection
   // ------------------------------------------------------------
   assign take = cmd_valid_i & cmd_ready_o;
   assign line_done = take & in_line & saw_cr & (cmd_data_i == CH_LF);

   // '@' opens a line, cr lf closes it; bytes outside a line are dropped
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         line_len <= '0;
         in_line <= 1'b0;
         saw_cr <= 1'b0;
         too_long <= 1'b0;
      end else if (state == ST_EXEC) begin
         in_line <= 1'b0;
         saw_cr <= 1'b0;
      end else if (take) begin
         if (cmd_data_i == CH_AT) begin
            in_line <= 1'b1;
            line_len <= '0;
            saw_cr <= 1'b0;
            too_long <= 1'b0;
         end else if (cmd_data_i == CH_CR) begin
            saw_cr <= in_line;
         end else if (!line_done) begin
            saw_cr <= 1'b0;
            if (in_line && line_len == 4'(LINE_DEPTH)) begin
               too_long <= 1'b1;
            end else if (in_line) begin
               line_len <= line_len + 4'h1;
            end
         end
      end
   end

   // line storage; a stray cr inside a line is never stored and does not advance the length
   always_ff @(posedge ref_clk_i) begin
      if (take && in_line && line_len < 4'(LINE_DEPTH) && cmd_data_i != CH_CR) begin
         line_buf[line_len] <= cmd_data_i;
      end
   end

   // ------------------------------------------------------------
   // command decode, evaluated in the execute state
   // ------------------------------------------------------------
   always_comb begin
      name = {line_buf[0], line_buf[1], line_buf[2]};
      grp_set = (name == NAME_GROUP) && (line_len > NAME_LEN) && (line_buf[3] == CH_COLON);
      base = grp_set ? GROUP_ARG_END : NAME_LEN;
      rest = (line_len >= base) ? line_len - base : 4'hf;
      has_addr = (rest == ADDR_LEN);
      addr = grp_set ? {line_buf[7], line_buf[8], line_buf[9]}
                     : {line_buf[3], line_buf[4], line_buf[5]};
      // method letter and number of a setting
      set_method = 3'(line_buf[4] - CH_A);
      set_num = 8'((line_buf[5] - CH_ZERO) * 8'd10) + 8'(line_buf[6] - CH_ZERO);
      set_ok = (line_buf[4] >= CH_A) && (line_buf[4] <= CH_G)
         && (line_buf[5] >= CH_ZERO) && (line_buf[5] <= CH_NINE)
         && (line_buf[6] >= CH_ZERO) && (line_buf[6] <= CH_NINE)
         && (set_num <= {1'b0, mhc_group_max(set_method)});
      bad = too_long || (rest != 4'h0 && !has_addr)
         || (has_addr && !rs485_mode_i)
         || (has_addr && name == NAME_DROP)
         || (grp_set && !set_ok)
         || !(name == NAME_SIGNAL || name == NAME_DROP || name == NAME_GROUP
              || name == NAME_RESTORE || name == NAME_MUTE || name == NAME_UNMUTE);
      // another station's command passes silently unless it is bad
      skip = !bad && has_addr && addr != station_addr_i && addr != group_addr_i;
   end

   // clamp and split the signal level into three decimal digits
   always_comb begin
      if (rssi_last > RSSI_TOP_DBM) begin
         rssi_clamp = RSSI_TOP_DBM;
      end else if (rssi_last < RSSI_FLOOR_DBM) begin
         rssi_clamp = RSSI_FLOOR_DBM;
      end else begin
         rssi_clamp = rssi_last;
      end
      mag = 7'(-rssi_clamp);
      mag_rem = (mag >= 7'd100) ? mag - 7'd100 : mag;
   end

   // answer body for the current command or for the end of a link drop
   always_comb begin
      for (int i = 0; i < RESP_BODY; i++) begin
         next_resp[i] = CH_ZERO;
      end
      next_resp[0] = CH_N;
      next_resp_n = 4'h2;
      load_resp = 1'b0;
      if (state == ST_WAIT) begin
         load_resp = drop_done_i | drop_fail_i;
         next_resp[0] = drop_done_i ? CH_P : CH_N;
         next_resp[1] = drop_done_i ? CH_ZERO : CH_ONE;
      end else if (state == ST_EXEC && !skip) begin
         load_resp = 1'b1;
         if (bad) begin
            next_resp[1] = CH_ZERO;
         end else if (name == NAME_SIGNAL) begin
            next_resp[0] = CH_MINUS;
            next_resp[1] = (mag >= 7'd100) ? CH_ONE : CH_ZERO;
            next_resp[2] = CH_ZERO + 8'(mag_rem / 7'd10);
            next_resp[3] = CH_ZERO + 8'(mag_rem % 7'd10);
            next_resp[4] = CH_LOW_D;
            next_resp[5] = CH_B;
            next_resp[6] = CH_LOW_M;
            next_resp_n = 4'h7;
         end else if (name == NAME_DROP) begin
            if (!transparent_mode_i) begin
               next_resp[1] = CH_ZERO;
            end else if (!link_up_i) begin
               next_resp[1] = 8'h34;
            end else begin
               next_resp[0] = CH_P;
               next_resp[1] = CH_ONE;
            end
         end else if (name == NAME_GROUP && !grp_set) begin
            next_resp[0] = CH_A + 8'(grp_method_o);
            next_resp[1] = CH_ZERO + 8'(grp_num_o / 7'd10);
            next_resp[2] = CH_ZERO + 8'(grp_num_o % 7'd10);
            next_resp_n = 4'h3;
         end else begin
            next_resp[0] = CH_P;
         end
      end
   end

   // ------------------------------------------------------------
   // control state
   // ------------------------------------------------------------
   assign slot_free = !resp_valid_o | resp_ready_i;

   always_comb begin
      next_state = state;
      unique case (state)
         ST_COLLECT: if (line_done) next_state = ST_EXEC;
         ST_EXEC: next_state = skip ? ST_COLLECT : ST_SEND;
         ST_SEND: begin
            if (slot_free && resp_idx == resp_len) begin
               next_state = drop_pend ? ST_WAIT : ST_COLLECT;
            end
         end
         ST_WAIT: if (load_resp) next_state = ST_SEND;
      endcase
   end

   // commands are refused while one is still being answered
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= ST_COLLECT;
         cmd_ready_o <= 1'b0;
      end else begin
         state <= next_state;
         cmd_ready_o <= (next_state == ST_COLLECT) && !line_done;
      end
   end

   // ------------------------------------------------------------
   // answer buffer and byte output
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (load_resp) begin
         for (int i = 0; i < RESP_DEPTH; i++) begin
            if (4'(i) < next_resp_n) begin
               resp_buf[i] <= next_resp[(i < RESP_BODY) ? i : 0];
            end else if (4'(i) == next_resp_n) begin
               resp_buf[i] <= CH_CR;
            end else begin
               resp_buf[i] <= CH_LF;
            end
         end
      end
   end

   // one byte at a time, held until the terminal side takes it
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         resp_len <= '0;
         resp_idx <= '0;
         resp_valid_o <= 1'b0;
         resp_data_o <= '0;
      end else if (load_resp) begin
         resp_len <= next_resp_n + 4'h2;
         resp_idx <= '0;
      end else if (state == ST_SEND && slot_free) begin
         if (resp_idx != resp_len) begin
            resp_valid_o <= 1'b1;
            resp_data_o <= resp_buf[resp_idx];
            resp_idx <= resp_idx + 4'h1;
         end else begin
            resp_valid_o <= 1'b0;
         end
      end else if (resp_ready_i) begin
         resp_valid_o <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // side effects of accepted commands
   // ------------------------------------------------------------
   // link drop request and the pending final answer
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         drop_req_o <= 1'b0;
         drop_pend <= 1'b0;
      end else begin
         drop_req_o <= 1'b0;
         if (state == ST_EXEC && !bad && !skip && name == NAME_DROP
             && transparent_mode_i && link_up_i) begin
            drop_req_o <= 1'b1;
            drop_pend <= 1'b1;
         end else if (state == ST_WAIT && load_resp) begin
            drop_pend <= 1'b0;
         end
      end
   end

   // restore pulses; group-addressed restore also clears the station address
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         factory_restore_o <= 1'b0;
         station_addr_reset_o <= 1'b0;
      end else begin
         factory_restore_o <= state == ST_EXEC && !bad && !skip && name == NAME_RESTORE;
         station_addr_reset_o <= state == ST_EXEC && !bad && !skip && name == NAME_RESTORE
            && has_addr && addr == group_addr_i;
      end
   end

   // working channel group; the stored default is caught after reset
   // release, never under the reset itself
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         defaults_loaded <= 1'b0;
         grp_method_o <= METHOD_RESET;
         grp_num_o <= GROUP_RESET;
      end else if (!defaults_loaded) begin
         defaults_loaded <= 1'b1;
         grp_method_o <= default_method_i;
         grp_num_o <= default_group_i;
      end else if (state == ST_EXEC && !bad && !skip && grp_set) begin
         grp_method_o <= set_method;
         grp_num_o <= set_num[6:0];
      end
   end

   // level of the last received packet, kept until the next one
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rssi_last <= RSSI_RESET;
      end else if (rssi_valid_i) begin
         rssi_last <= rssi_dbm_i;
      end
   end

   // mute flag starts cleared so received data flows after reset
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_muted_o <= 1'b0;
      end else if (state == ST_EXEC && !bad && !skip && name == NAME_MUTE) begin
         rx_muted_o <= 1'b1;
      end else if (state == ST_EXEC && !bad && !skip && name == NAME_UNMUTE) begin
         rx_muted_o <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // received radio data path
   // ------------------------------------------------------------
   // while muted the buffer fills and its ready stalls the radio side
   mhc_rx_buffer #(
      .WIDTH(RX_WIDTH),
      .DEPTH(RX_DEPTH)
   ) u_rx_buffer (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(rx_valid_i),
      .in_data_i(rx_data_i),
      .in_ready_o(rx_ready_o),
      .out_valid_o(buf_valid),
      .out_data_o(buf_data),
      .out_ready_i(buf_ready)
   );

   assign buf_ready = !rx_muted_o && (!term_valid_o || term_ready_i);

   // output stage; a word already staged before mute still leaves
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         term_valid_o <= 1'b0;
         term_data_o <= '0;
      end else if (buf_ready) begin
         term_valid_o <= buf_valid;
         term_data_o <= buf_data;
      end else if (term_ready_i) begin
         term_valid_o <= 1'b0;
      end
   end

endmodule : mhc_command_unit

// [rtl/mhc_pkg.sv]
// shared constants, types and helpers of the modem host command unit
package mhc_pkg;

   // ------------------------------------------------------------
   // characters of the text protocol
   // ------------------------------------------------------------
   localparam logic [7:0] CH_AT = 8'h40;
   localparam logic [7:0] CH_CR = 8'h0d;
   localparam logic [7:0] CH_LF = 8'h0a;
   localparam logic [7:0] CH_COLON = 8'h3a;
   localparam logic [7:0] CH_ZERO = 8'h30;
   localparam logic [7:0] CH_NINE = 8'h39;
   localparam logic [7:0] CH_ONE = 8'h31;
   localparam logic [7:0] CH_MINUS = 8'h2d;
   localparam logic [7:0] CH_P = 8'h50;
   localparam logic [7:0] CH_N = 8'h4e;
   localparam logic [7:0] CH_A = 8'h41;
   localparam logic [7:0] CH_G = 8'h47;
   localparam logic [7:0] CH_LOW_D = 8'h64;
   localparam logic [7:0] CH_B = 8'h42;
   localparam logic [7:0] CH_LOW_M = 8'h6d;

   // ------------------------------------------------------------
   // command names, three ascii characters each
   // ------------------------------------------------------------
   localparam logic [23:0] NAME_SIGNAL = 24'h44424d;
   localparam logic [23:0] NAME_DROP = 24'h44434e;
   localparam logic [23:0] NAME_GROUP = 24'h465251;
   localparam logic [23:0] NAME_RESTORE = 24'h494e49;
   localparam logic [23:0] NAME_MUTE = 24'h4f4441;
   localparam logic [23:0] NAME_UNMUTE = 24'h4f454e;

   // ------------------------------------------------------------
   // sizes, field positions and reset values
   // ------------------------------------------------------------
   localparam int LINE_DEPTH = 12;          // longest line body kept
   localparam int RESP_DEPTH = 9;           // longest answer incl. cr lf
   localparam int RESP_BODY = 7;            // longest answer body
   localparam logic [3:0] NAME_LEN = 4'h3;  // command name characters
   localparam logic [3:0] ADDR_LEN = 4'h3;  // station address characters
   localparam logic [3:0] GROUP_ARG_END = 4'h7; // name + ':' + letter + 2 digits
   localparam logic signed [7:0] RSSI_TOP_DBM = 8'sh d8;   // -40 dBm
   localparam logic signed [7:0] RSSI_FLOOR_DBM = 8'sh 9c; // -100 dBm
   localparam logic signed [7:0] RSSI_RESET = 8'sh 9c;
   localparam logic [2:0] METHOD_RESET = 3'h0;
   localparam logic [6:0] GROUP_RESET = 7'h00;
   localparam logic [2:0] METHOD_LAST = 3'h6;   // method letter g

   // ------------------------------------------------------------
   // control states, one-hot
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_COLLECT = 4'b0001,
      ST_EXEC = 4'b0010,
      ST_SEND = 4'b0100,
      ST_WAIT = 4'b1000
   } mhc_state_type;

   // highest group number allowed for each grouping method a..g
   function automatic logic [6:0] mhc_group_max(input logic [2:0] method);
      case (method)
         3'h0: mhc_group_max = 7'h4b;   // 75
         3'h1: mhc_group_max = 7'h25;   // 37
         3'h2: mhc_group_max = 7'h18;   // 24
         3'h3: mhc_group_max = 7'h12;   // 18
         3'h4: mhc_group_max = 7'h0b;   // 11
         3'h5: mhc_group_max = 7'h08;   // 8
         default: mhc_group_max = 7'h05; // 5
      endcase
   endfunction : mhc_group_max

endpackage : mhc_pkg

// [rtl/mhc_rx_buffer.sv]
// small valid/ready fifo holding received radio data on its way out
`timescale 1ns/1ns
module mhc_rx_buffer #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [PW:0] count;
   logic [PW:0] next_count;
   logic push;
   logic pop;

   // empty straight from the fill count; ready is a flop, set from the next count
   assign out_valid_o = (count != '0);
   assign out_data_o = mem[rd_ptr];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   assign next_count = count + (PW+1)'(push) - (PW+1)'(pop);

   // storage, written only on an accepted word
   always_ff @(posedge ref_clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   // pointers wrap at depth, which need not be a power of two
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         in_ready_o <= 1'b1;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= next_count;
         // registered so the radio side sees ready from a flop, no extra delay
         in_ready_o <= (next_count != (PW+1)'(DEPTH));
      end
   end

endmodule : mhc_rx_buffer

// [tb/mhc_command_unit_test.sv]
// bench of the host command unit against a queue model
`timescale 1ns/1ns
module mhc_command_unit_test;
   logic ref_clk_i = 1'b0, rst_n_i = 1'b0, rs485_mode_i = 1'b0, transparent_mode_i = 1'b0;
   logic cmd_valid_i, cmd_ready_o, resp_valid_o, resp_ready_i, drop_req_o, rx_muted_o;
   logic link_up_i = 1'b0, drop_done_i = 1'b0, drop_fail_i = 1'b0, rssi_valid_i = 1'b0;
   logic rx_valid_i = 1'b0, term_ready_i = 1'b0;
   logic factory_restore_o, station_addr_reset_o, rx_ready_o, term_valid_o;
   logic [7:0] cmd_data_i, resp_data_o, rx_data_i = 8'h00, term_data_o, q[$];
   logic signed [7:0] rssi_dbm_i = 8'sh00;
   logic [23:0] station_addr_i = 24'h303037, group_addr_i = 24'h413939;
   logic [2:0] grp_method_o, default_method_i = 3'h5;
   logic [6:0] grp_num_o, default_group_i = 7'h00;
   int miscompares = 0, cmp_count = 0, cycles = 0, outs = 0, drops = 0, rests = 0, g = 0;
   int top[8] = '{75, 37, 24, 18, 11, 8, 5, 0};
   // command names built from the package encoding
   string n_sig, n_drop, n_grp, n_rst, n_mute, n_unm;
   mhc_command_unit mhc_command_unit_inst (.*);
   mhc_terminal_model host (.ref_clk_i(ref_clk_i), .cmd_ready_i(cmd_ready_o),
      .cmd_valid_o(cmd_valid_i), .cmd_data_o(cmd_data_i), .resp_valid_i(resp_valid_o),
      .resp_data_i(resp_data_o), .resp_ready_o(resp_ready_i));
   always #10 ref_clk_i = ~ref_clk_i;
   task automatic check(input string what, input string seen, input string exp);
      cmp_count++;
      if (seen != exp) begin
         miscompares++;
         $display("[FAIL] %s expected %s seen %s", what, exp, seen);
      end
   endtask : check
   task automatic wrap_up;
      if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   // terminal side stalls at random; words must leave in arrival order
   always @(negedge ref_clk_i) begin
      term_ready_i = 1'($urandom_range(0, 1));
      if (term_valid_o === 1'b1 && term_ready_i) begin
         check("term", $sformatf("%h", term_data_o), $sformatf("%h", q.pop_front()));
         outs++;
      end
      drops += drop_req_o;
      rests += factory_restore_o + station_addr_reset_o;
      cycles++;
      if (cycles > 30000) begin
         miscompares++;
         wrap_up;
      end
   end
   task automatic cmd(input string line, input string exp);
      host.got = "";
      host.send({"@", line, "\r\n"});
      for (int i = 0; i < 500 && host.got.len() < exp.len() + 2; i++) @(negedge ref_clk_i);
      check(line, host.got, {exp, "\r\n"});
   endtask : cmd
   task automatic push(input logic [7:0] d);
      @(negedge ref_clk_i);
      rx_valid_i = 1'b1;
      rx_data_i = d;
      while (!rx_ready_o) @(negedge ref_clk_i);
      q.push_back(d);
      @(negedge ref_clk_i);
      rx_valid_i = 1'b0;
      rx_data_i = ~d;
   endtask : push
   task automatic level(input int d);
      @(negedge ref_clk_i);
      rssi_valid_i = 1'b1;
      rssi_dbm_i = 8'(d);
      @(negedge ref_clk_i);
      rssi_valid_i = 1'b0;
      cmd(n_sig, $sformatf("-%03ddBm", d > -40 ? 40 : (d < -100 ? 100 : -d)));
   endtask : level
   // radio reports the outcome a few cycles after the first answer
   task automatic answer(input int k);
      // wait for this drop's own request, so a stale answer length cannot fire early
      @(posedge drop_req_o);
      wait (host.got.len() == 4);
      repeat (3) @(negedge ref_clk_i);
      {drop_fail_i, drop_done_i} = k ? 2'b10 : 2'b01;
      @(negedge ref_clk_i);
      {drop_fail_i, drop_done_i} = 2'b00;
   endtask : answer
   initial begin
      void'($urandom(32'h8482));
      n_sig = $sformatf("%s", mhc_pkg::NAME_SIGNAL);
      n_drop = $sformatf("%s", mhc_pkg::NAME_DROP);
      n_grp = $sformatf("%s", mhc_pkg::NAME_GROUP);
      n_rst = $sformatf("%s", mhc_pkg::NAME_RESTORE);
      n_mute = $sformatf("%s", mhc_pkg::NAME_MUTE);
      n_unm = $sformatf("%s", mhc_pkg::NAME_UNMUTE);
      repeat (4) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      rst_n_i = 1'b1;
      repeat (2) @(negedge ref_clk_i);
      check("init", $sformatf("%h%h%b", grp_method_o, grp_num_o, rx_muted_o), "5000");
      cmd(n_grp, "F00");
      // every method, a number up to its top (the top itself for b, d, f) and one past; nothing transmits meanwhile
      for (int m = 0; m < 8; m++) begin
         g = m == 7 ? g : (m[0] ? top[m] : $urandom_range(0, top[m]));
         cmd($sformatf("%s:%c%02d", n_grp, 8'h41 + m, g), m < 7 ? "P0" : "N0");
         cmd($sformatf("%s:%c%02d", n_grp, 8'h41 + m, top[m] + 1), "N0");
         if (m < 7) cmd(n_grp, $sformatf("%c%02d", 8'h41 + m, g));
      end
      check("grp", $sformatf("%0d %0d", grp_method_o, grp_num_o), $sformatf("6 %0d", g));
      level(-78);
      level(-20);
      level(-120);
      level(-40 - int'($urandom_range(0, 60)));
      cmd(n_drop, "N0");
      transparent_mode_i = 1'b1;
      cmd(n_drop, "N4");
      link_up_i = 1'b1;
      for (int k = 0; k < 2; k++) fork
         cmd(n_drop, k ? "P1\r\nN1" : "P1\r\nP0");
         answer(k);
      join
      check("drop", $sformatf("%0d", drops), "2");
      rs485_mode_i = 1'b1;
      cmd({n_rst, "A99"}, "P0");
      cmd({n_mute, "007"}, "P0");
      rs485_mode_i = 1'b0;
      cmd({n_rst, "007"}, "N0");
      repeat (2) push(8'($urandom_range(0, 255)));
      repeat (9) @(negedge ref_clk_i);
      check("hold", $sformatf("%0d%b%b%0d", rests, rx_muted_o, rx_ready_o, outs), "2100");
      cmd(n_unm, "P0");
      repeat (2) push(8'($urandom_range(0, 255)));
      for (int i = 0; i < 99 && q.size() > 0; i++) @(negedge ref_clk_i);
      check("drain", $sformatf("%0d %0d", outs, q.size()), "4 0");
      wrap_up;
   end
endmodule : mhc_command_unit_test

// [tb/mhc_properties.sv]
// port assertions of the host command unit
`timescale 1ns/1ns
module mhc_properties (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic cmd_ready_o,
   input wire logic resp_valid_o,
   input wire logic [7:0] resp_data_o,
   input wire logic resp_ready_i,
   input wire logic drop_req_o,
   input wire logic factory_restore_o,
   input wire logic station_addr_reset_o,
   input wire logic rx_muted_o,
   input wire logic term_valid_o,
   input wire logic [7:0] term_data_o,
   input wire logic term_ready_i
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // -----------------------------------------
   // answers, side pulses and data handshakes
   // -----------------------------------------
   chk_resp_hold:
   assert property (resp_valid_o && !resp_ready_i |=> resp_valid_o && $stable(resp_data_o))
      else $error("answer byte lost");
   chk_busy_refuse:
   assert property (resp_valid_o |-> !cmd_ready_o) else $error("byte taken mid answer");
   chk_drop_pulse:
   assert property (drop_req_o |-> !cmd_ready_o ##1 !drop_req_o) else $error("bad drop pulse");
   chk_restore_pulse:
   assert property (factory_restore_o |=> !factory_restore_o) else $error("long restore");
   chk_restore_busy:
   assert property (factory_restore_o |-> !cmd_ready_o) else $error("restore while idle");
   chk_addr_pair:
   assert property (station_addr_reset_o |-> factory_restore_o) else $error("lone addr reset");
   chk_mute_blocks:
   assert property (rx_muted_o && !term_valid_o |=> !term_valid_o) else $error("muted output");
   chk_term_hold:
   assert property (term_valid_o && !term_ready_i |=> term_valid_o && $stable(term_data_o))
      else $error("terminal word lost");
endmodule : mhc_properties
bind mhc_command_unit mhc_properties mhc_properties_inst (.*);

// [tb/mhc_terminal_model.sv]
// terminal model: sends command lines, gathers answers
`timescale 1ns/1ns
module mhc_terminal_model (
   input wire logic ref_clk_i,
   input wire logic cmd_ready_i,
   output logic cmd_valid_o,
   output logic [7:0] cmd_data_o,
   input wire logic resp_valid_i,
   input wire logic [7:0] resp_data_i,
   output logic resp_ready_o
);
   string got = "";
   bit take;
   initial begin
      cmd_valid_o = 1'b0;
      cmd_data_o = 8'h00;
      resp_ready_o = 1'b0;
   end
   // one byte per handshake, held until ready is seen at an edge
   task automatic send(input string s);
      for (int i = 0; i < s.len(); i++) begin
         @(negedge ref_clk_i);
         cmd_valid_o = 1'b1;
         cmd_data_o = s[i];
         while (!cmd_ready_i) @(negedge ref_clk_i);
      end
      @(negedge ref_clk_i);
      cmd_valid_o = 1'b0;
      cmd_data_o = ~cmd_data_o;
   endtask : send
   // stalls at random; a byte counts once ready is committed for the edge
   always @(negedge ref_clk_i) begin
      take = ($urandom_range(0, 3) != 0);
      resp_ready_o = take;
      if (resp_valid_i === 1'b1 && take) got = {got, string'(resp_data_i)};
   end
endmodule : mhc_terminal_model
